// >>> hdl/conv_port.sv
// Digital side of the two-wire converter port
`timescale 1ns/1ps
module conv_port #(
   parameter int unsigned WINDOW_CYCLES = conv_port_pkg::REDUCE_WINDOW_CYCLES,
   parameter int unsigned CONV_CYCLES = conv_port_pkg::CONV_CYCLES_FULL
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // Two-wire link
   input wire logic conv_clk_in,
   output logic conv_data_line_out,
   // Channel select pins
   input wire logic chan_sel_lo_in,
   input wire logic chan_sel_hi_in,
   // Analog side
   input wire conv_port_pkg::conv_result_s result_in,
   output logic conv_run_out,
   output conv_port_pkg::chan_sel_s chan_out,
   output logic [2:0] reduce_count_out,
   // Power-fail comparator (above threshold = 1)
   input wire logic fail_sense_above_in,
   output logic fail_flag_output_out,
   output logic fail_flag_output_oe_n_out
);
   logic [1:0] clk_sync_reg;
   logic [1:0] sel_lo_sync_reg;
   logic [1:0] sel_hi_sync_reg;
   logic [1:0] fail_sync_reg;
   logic clk_level;
   logic clk_fall;
   logic clk_rise;
   conv_port_pkg::port_state_e state_reg;
   logic [31:0] timer_reg;
   logic [2:0] reduce_reg;
   logic [15:0] shift_reg;
   logic [4:0] edge_reg;
   logic ack_reg;
   logic in_idle;
   logic in_reduce;
   logic in_busy;
   logic in_read;
   logic start_take;
   logic reduce_take;
   logic window_end;
   logic conv_done;
   logic first_out;
   logic cycle_full;

   // Decoded state and event strobes
   assign in_idle = (state_reg == conv_port_pkg::ST_IDLE);
   assign in_reduce = (state_reg == conv_port_pkg::ST_REDUCE);
   assign in_busy = (state_reg == conv_port_pkg::ST_BUSY);
   assign in_read = (state_reg == conv_port_pkg::ST_READ);
   assign start_take = in_idle && clk_fall;
   assign reduce_take = in_reduce && clk_fall && (reduce_reg < 3'(conv_port_pkg::MAX_REDUCE));
   assign window_end = in_reduce && (timer_reg >= WINDOW_CYCLES - 1);
   assign conv_done = in_busy && ((timer_reg >= (CONV_CYCLES >> reduce_reg)) || result_in.valid);
   // Ready level stands until the first readout edge
   assign first_out = (edge_reg == 5'(1 + reduce_reg));
   // Every edge of the cycle seen; last bit stands until the rise
   assign cycle_full = (edge_reg >= 5'(conv_port_pkg::CYCLE_EDGES));

   // Two-flop synchronisers for all pin inputs
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         clk_sync_reg <= 2'h3;
         sel_lo_sync_reg <= 2'h0;
         sel_hi_sync_reg <= 2'h0;
         fail_sync_reg <= 2'h0;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], conv_clk_in};
         sel_lo_sync_reg <= {sel_lo_sync_reg[0], chan_sel_lo_in};
         sel_hi_sync_reg <= {sel_hi_sync_reg[0], chan_sel_hi_in};
         fail_sync_reg <= {fail_sync_reg[0], fail_sense_above_in};
      end
   end

   // Glitch filter on the clock line
   pulse_filter #(
      .WIDTH(conv_port_pkg::FILTER_CYCLES)
   ) u_filter (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .line_in(clk_sync_reg[1]),
      .level_out(clk_level),
      .fall_out(clk_fall),
      .rise_out(clk_rise)
   );

   // Sequence state
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_reg <= conv_port_pkg::ST_IDLE;
      end else begin
         unique case (state_reg)
            conv_port_pkg::ST_IDLE: begin
               if (start_take) begin
                  state_reg <= conv_port_pkg::ST_REDUCE;
               end
            end
            conv_port_pkg::ST_REDUCE: begin
               if (window_end) begin
                  state_reg <= conv_port_pkg::ST_BUSY;
               end
            end
            conv_port_pkg::ST_BUSY: begin
               if (conv_done) begin
                  state_reg <= conv_port_pkg::ST_READ;
               end
            end
            conv_port_pkg::ST_READ: begin
               // Leave on the rise so the last bit stands while low
               if (clk_rise && cycle_full) begin
                  state_reg <= conv_port_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Window and conversion timer
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || in_idle || window_end) begin
         timer_reg <= 32'h0;
      end else if (in_reduce || in_busy) begin
         timer_reg <= timer_reg + 32'h1;
      end
   end

   // Accepted reduction edges, capped at the minimum resolution
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || start_take) begin
         reduce_reg <= 3'h0;
      end else if (reduce_take) begin
         reduce_reg <= reduce_reg + 3'h1;
      end
   end

   // Falling edges of the current cycle; ignored edges not counted
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         edge_reg <= 5'h0;
      end else if (start_take) begin
         edge_reg <= 5'h1;
      end else if (reduce_take || (in_read && clk_fall && !cycle_full)) begin
         edge_reg <= edge_reg + 5'h1;
      end
   end

   // Acknowledge level for start and reduction edges
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         ack_reg <= 1'b0;
      end else if (start_take) begin
         ack_reg <= 1'b1;
      end else if (window_end) begin
         ack_reg <= 1'b0;
      end else if (reduce_take) begin
         ack_reg <= 1'b1;
      end else if (clk_rise) begin
         ack_reg <= 1'b0;
      end
   end

   // Result word: load on completion, shift on readout edges
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         shift_reg <= 16'h0000;
      end else if (conv_done) begin
         if (result_in.value == conv_port_pkg::RESULT_RESERVED) begin
            shift_reg <= conv_port_pkg::RESULT_MIN;
         end else begin
            shift_reg <= result_in.value;
         end
      end else if (in_read && clk_fall && !first_out && !cycle_full) begin
         // First edge only exposes the sign; later edges advance
         shift_reg <= {shift_reg[14:0], 1'b0};
      end
   end

   // Channel select latched by the start edge
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         chan_out <= '0;
      end else if (start_take) begin
         chan_out <= {sel_hi_sync_reg[1], sel_lo_sync_reg[1]};
      end
   end

   // Data line: high idle/ack/ready, low busy, else current result bit
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         conv_data_line_out <= 1'b1;
         conv_run_out <= 1'b0;
         reduce_count_out <= 3'h0;
      end else begin
         conv_run_out <= (state_reg == conv_port_pkg::ST_REDUCE) ||
                         (state_reg == conv_port_pkg::ST_BUSY);
         reduce_count_out <= reduce_reg;
         unique case (state_reg)
            conv_port_pkg::ST_IDLE: conv_data_line_out <= 1'b1;
            conv_port_pkg::ST_REDUCE: conv_data_line_out <= ack_reg;
            conv_port_pkg::ST_BUSY: conv_data_line_out <= 1'b0;
            conv_port_pkg::ST_READ: begin
               // Before first readout edge the line shows ready high
               if (first_out) begin
                  conv_data_line_out <= 1'b1;
               end else begin
                  conv_data_line_out <= shift_reg[15];
               end
            end
         endcase
      end
   end

   // Power-fail flag: pull low below threshold, release above
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         fail_flag_output_out <= 1'b0;
         fail_flag_output_oe_n_out <= 1'b0;
      end else begin
         fail_flag_output_out <= 1'b0;
         fail_flag_output_oe_n_out <= fail_sync_reg[1];
      end
   end
endmodule : conv_port

// >>> hdl/pulse_filter.sv
// Glitch filter and edge finder for the conversion clock line
`timescale 1ns/1ps
module pulse_filter #(
   parameter int unsigned WIDTH = 2
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // Raw line, already synchronised
   input wire logic line_in,
   // Filtered level and edges
   output logic level_out,
   output logic fall_out,
   output logic rise_out
);
   logic [7:0] count_reg;

   // Accept a new level only after it has held WIDTH cycles
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         count_reg <= 8'h00;
         level_out <= 1'b1;
         fall_out <= 1'b0;
         rise_out <= 1'b0;
      end else begin
         fall_out <= 1'b0;
         rise_out <= 1'b0;
         if (line_in == level_out) begin
            count_reg <= 8'h00;
         end else if (count_reg >= 8'(WIDTH - 1)) begin
            count_reg <= 8'h00;
            level_out <= line_in;
            fall_out <= ~line_in;
            rise_out <= line_in;
         end else begin
            count_reg <= count_reg + 8'h01;
         end
      end
   end
endmodule : pulse_filter

// >>> pkg/conv_port_pkg.sv
// Constants and carrier types for the two-wire converter port
package conv_port_pkg;
   // System clock period in picoseconds (40 MHz)
   localparam int unsigned CLK_PERIOD_PS = 25000;
   // Clock-line glitch filter width, ns (rounded up to whole cycles)
   localparam int unsigned FILTER_MIN_NS = 50;
   localparam int unsigned FILTER_CYCLES =
      (FILTER_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Word geometry
   localparam int unsigned WORD_BITS = 16;
   localparam int unsigned MIN_RES_BITS = 10;
   localparam int unsigned MAX_REDUCE = WORD_BITS - MIN_RES_BITS;
   localparam int unsigned CYCLE_EDGES = 17;
   // Result limits in two's complement
   localparam logic [15:0] RESULT_MAX = 16'h7FFF;
   localparam logic [15:0] RESULT_MIN = 16'h8001;
   localparam logic [15:0] RESULT_RESERVED = 16'h8000;
   // Default window and conversion lengths in system cycles
   localparam int unsigned REDUCE_WINDOW_CYCLES = 4000;
   localparam int unsigned CONV_CYCLES_FULL = 64000;

   // Port states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_REDUCE = 2'b01,
      ST_BUSY = 2'b10,
      ST_READ = 2'b11
   } port_state_e;

   // Result handed over by the analog side
   typedef struct packed {
      logic valid;
      logic [15:0] value;
   } conv_result_s;

   // Channel select latched at start
   typedef struct packed {
      logic hi;
      logic lo;
   } chan_sel_s;
endpackage : conv_port_pkg

// >>> test/conv_port_sva.sv
// Property checks for the converter port
`timescale 1ns/1ps
module conv_port_sva (
   // Watched ports
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic conv_clk_in,
   input wire logic conv_data_line_out,
   input wire logic conv_run_out,
   input wire conv_port_pkg::chan_sel_s chan_out,
   input wire logic [2:0] reduce_count_out,
   input wire logic fail_sense_above_in,
   input wire logic fail_flag_output_out,
   input wire logic fail_flag_output_oe_n_out
);
   logic [3:0] low_age_reg;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // Cycles since the clock pin was last low
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) low_age_reg <= 4'hF;
      else if (!conv_clk_in) low_age_reg <= 4'h0;
      else if (low_age_reg != 4'hF) low_age_reg <= low_age_reg + 4'h1;
   end
   // Acknowledge dropped or run ended
   sequence ack_drop;
      ##[2:8] (!conv_data_line_out || !conv_run_out);
   endsequence
   flag_zero_a: assert property (fail_flag_output_out == 1'b0)
      else $error("flag pin value high");
   flag_follow_a: assert property ($stable(fail_sense_above_in) [*6] |->
      fail_flag_output_oe_n_out == fail_sense_above_in) else $error("flag not following");
   reduce_cap_a: assert property (reduce_count_out <= 3'h6)
      else $error("too many reductions");
   count_step_a: assert property ($changed(reduce_count_out) |->
      reduce_count_out == $past(reduce_count_out) + 3'h1 || reduce_count_out == 3'h0)
      else $error("reduction count jumped");
   start_cause_a: assert property ($rose(conv_run_out) |-> low_age_reg <= 4'h6)
      else $error("start without clock fall");
   chan_hold_a: assert property (conv_run_out && $past(conv_run_out) |-> $stable(chan_out))
      else $error("channel moved in run");
   ack_release_a: assert property (conv_run_out && $rose(conv_clk_in) |-> ack_drop)
      else $error("ack not released");
   shift_cause_a: assert property (!conv_run_out && !$past(conv_run_out) &&
      !$past(conv_run_out, 2) && $changed(conv_data_line_out) |-> low_age_reg <= 4'hA)
      else $error("data moved without clock");
endmodule : conv_port_sva
bind conv_port conv_port_sva u_sva (.clk_sys_in, .reset_in, .conv_clk_in, .conv_data_line_out,
   .conv_run_out, .chan_out, .reduce_count_out, .fail_sense_above_in, .fail_flag_output_out,
   .fail_flag_output_oe_n_out);

// >>> test/conv_port_test.sv
// Self-checking bench for the converter port
`timescale 1ns/1ps
module conv_port_test;
   localparam int WIN = 400;
   logic clk_sys_in = 1'b0, reset_in = 1'b1, lo = 1'b0, hi = 1'b0, above = 1'b0;
   logic line, data, run, flag, oe_n;
   logic [2:0] cnt;
   conv_port_pkg::conv_result_s res = '0;
   conv_port_pkg::chan_sel_s chan;
   int n_mismatch = 0, checked = 0, cyc = 0;
   always #12.5 clk_sys_in = ~clk_sys_in;
   link_host host (.data_in(data), .clk_line_out(line));
   conv_port #(.WINDOW_CYCLES(WIN), .CONV_CYCLES(800)) DUT (.clk_sys_in, .reset_in,
      .conv_clk_in(line), .conv_data_line_out(data), .chan_sel_lo_in(lo), .chan_sel_hi_in(hi),
      .result_in(res), .conv_run_out(run), .chan_out(chan), .reduce_count_out(cnt),
      .fail_sense_above_in(above), .fail_flag_output_out(flag), .fail_flag_output_oe_n_out(oe_n));
   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Verdict and end of run
   task automatic wrap_up;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Start, reduce, convert and read one word
   task automatic t_cycle(input logic [15:0] val, input logic [15:0] exp, input int nred);
      logic [2:0] pat;
      logic b;
      logic [15:0] word;
      word = 16'h0000;
      @(negedge clk_sys_in);
      {hi, lo} = val[1:0];
      res.value = val;
      host.decode(pat);
      check(16'(pat), 16'h0006);
      check(16'(chan), 16'(val[1:0]));
      for (int i = 0; i < nred; i++) begin
         host.decode(pat);
         check(16'(pat), 16'h0002);
      end
      // One edge past the floor must be ignored
      if (nred == conv_port_pkg::MAX_REDUCE) begin
         host.decode(pat);
         check(16'(pat), 16'h0000);
      end
      check(16'(cnt), 16'(nred));
      repeat (WIN) @(negedge clk_sys_in);
      res.valid = 1'b1;
      @(negedge clk_sys_in);
      res.valid = 1'b0;
      for (int k = 0; k < 2000 && data !== 1'b1; k++) @(negedge clk_sys_in);
      check(16'(data), 16'h0001);
      // First readout edge decoded as a transfer pattern
      host.decode(pat);
      check(16'(pat), {13'h0000, 1'h1, exp[15], exp[15]});
      word = 16'(pat[0]);
      for (int i = 1; i < 16 - nred; i++) begin
         host.strobe(b);
         word = {word[14:0], b};
      end
      check(word, exp >> nred);
      #400 check(16'({data, run}), 16'h0002);
      $display("cycle %h done", val);
   endtask : t_cycle
   // Short pulse on an idle line
   task automatic t_glitch;
      @(negedge clk_sys_in);
      host.glitch();
      repeat (20) @(negedge clk_sys_in);
      check(16'({data, run}), 16'h0002);
      $display("glitch done");
   endtask : t_glitch
   // Fail flag release and pull
   task automatic t_fail;
      above = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      check(16'({flag, oe_n}), 16'h0001);
      above = 1'b0;
      repeat (8) @(negedge clk_sys_in);
      check(16'({flag, oe_n}), 16'h0000);
      $display("fail flag done");
   endtask : t_fail
   // Main sequence
   initial begin
      repeat (12) @(negedge clk_sys_in);
      reset_in = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      t_glitch();
      t_fail();
      t_cycle(16'h8000, 16'h8001, 0);
      t_cycle(16'h7FFF, 16'h7FFF, 6);
      t_cycle(16'hFFF2, 16'hFFF2, 3);
      wrap_up();
   end
   // Cut a hang short
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
endmodule : conv_port_test

// >>> test/link_host.sv
// Host model driving the converter clock line
`timescale 1ns/1ps
module link_host (
   // Link
   input wire logic data_in,
   output logic clk_line_out
);
   initial clk_line_out = 1'b1;
   // One high-low-high pass, data sampled at each level
   task automatic decode(output logic [2:0] pat);
      pat[2] = data_in;
      clk_line_out = 1'b0;
      #200 pat[1] = data_in;
      clk_line_out = 1'b1;
      #200 pat[0] = data_in;
   endtask : decode
   // Readout edge, bit taken 90 ns after the rise lands
   task automatic strobe(output logic b);
      clk_line_out = 1'b0;
      #100 clk_line_out = 1'b1;
      #90 b = data_in;
      #10;
   endtask : strobe
   // Low pulse shorter than the filter
   task automatic glitch;
      clk_line_out = 1'b0;
      #25 clk_line_out = 1'b1;
   endtask : glitch
endmodule : link_host
